// File: logic/csf_pkg.sv
// constants, types and carriers of the cpu status flag logic
//
// Contract
// - arithmetic carry or borrow at bit 7 sets carry
// - rotate or shift loads carry with last out
// - set, clear and invert carry operations
// - arithmetic or logic zero result sets zero
// - bit test or shift zero result sets zero
// - sign flag copies result msb
// - overflow beyond +127 or -128 sets overflow
// - logic operations clear overflow
// - decimal flag records add or subtract, never condition
// - half carry from bit 3 or borrow bit 4
// - fast interrupt sets status, return clears it
// - status set blocks interrupts, selects fast return
// - bank select instructions clear or set bank bit
// - flags register bit order c z s v d h f b
// - only upper four flags serve as conditions
// - loads may write flags register directly
// - and updates zero, sign and overflow
// - register pairs even only, 0 to 254, 0 to 14
// - relative offset signed, added to next address
// - short index signed, long index unsigned 16 bit
`default_nettype none
package csf_pkg;

  // register location: printed offset is an index, byte address is four times it
  localparam logic [11:0] CSF_FLAGS_IDX  = 12'h0d5;
  localparam logic [11:0] CSF_FLAGS_ADDR = 12'h354;
  localparam logic [7:0]  CSF_FLAGS_RST  = 8'h00;

  // flag bit positions
  localparam int unsigned CSF_C   = 7;
  localparam int unsigned CSF_Z   = 6;
  localparam int unsigned CSF_S   = 5;
  localparam int unsigned CSF_V   = 4;
  localparam int unsigned CSF_D   = 3;
  localparam int unsigned CSF_H   = 2;
  localparam int unsigned CSF_FIS = 1;
  localparam int unsigned CSF_BA  = 0;

  // operation kinds presented by the decoder
  typedef enum logic [4:0] {
    OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_CMP,
    OP_AND, OP_OR, OP_XOR, OP_TST, OP_TCM,
    OP_RL, OP_RLC, OP_RR, OP_RRC, OP_SRA, OP_SWAP,
    OP_SETC, OP_CLRC, OP_INVC, OP_SELLO, OP_SELHI,
    OP_FIRQ, OP_INTERRUPT_RETURN_OP
  } csf_op_t;

  // one operation from the execution datapath
  typedef struct packed {
    logic       valid;
    csf_op_t    op;
    logic [7:0] a;
    logic [7:0] b;
  } csf_req_t;

  // operand address calculation request
  typedef struct packed {
    logic [7:0]  pair_reg;
    logic [3:0]  work_pair;
    logic [7:0]  rel_off;
    logic [15:0] next_pc;
    logic [15:0] pair_val;
    logic [15:0] long_off;
  } csf_areq_t;

  // operand address calculation answer
  typedef struct packed {
    logic [15:0] rel_tgt;
    logic [15:0] short_tgt;
    logic [15:0] long_tgt;
    logic        pair_ok;
    logic        work_ok;
  } csf_arsp_t;

endpackage
`default_nettype wire

// File: logic/csf_arith.sv
// eight bit adder and subtractor with carry, half carry and overflow
`timescale 1ns/10ps
`default_nettype none
module csf_arith
  import csf_pkg::*;
(
  // operands
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  input  wire logic       sub,
  // results
  output logic      [7:0] res,
  output logic            cout,
  output logic            half,
  output logic            ovf
);
  logic [7:0] bx;   // b, inverted for subtraction
  logic       ci;   // carry into bit 0
  logic [8:0] s9;   // full sum
  logic [4:0] s5;   // low nibble sum

  // subtraction is a plus not b plus not borrow
  assign bx   = sub ? ~b : b;
  assign ci   = sub ? ~cin : cin;
  assign s9   = {1'b0, a} + {1'b0, bx} + {8'h00, ci};
  assign s5   = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
  assign res  = s9[7:0];
  // carry out, or borrow into bit 7
  assign cout = sub ? ~s9[8] : s9[8];
  assign half = sub ? ~s5[4] : s5[4];
  // signed range left when operand signs agree but result differs
  assign ovf  = (a[7] == bx[7]) && (res[7] != a[7]);
endmodule // csf_arith
`default_nettype wire

// File: logic/csf_addr_calc.sv
// operand address calculation for pair, relative and indexed modes
`timescale 1ns/10ps
`default_nettype none
module csf_addr_calc
  import csf_pkg::*;
(
  // clock and reset
  input  wire logic      core_clk,
  input  wire logic      nrst,
  // request and answer
  input  wire csf_areq_t areq,
  output csf_arsp_t      arsp
);
  logic [15:0] rel_sx;   // sign extended relative offset
  csf_arsp_t   next_rsp; // answer before the register

  assign rel_sx             = {{8{areq.rel_off[7]}}, areq.rel_off};
  assign next_rsp.rel_tgt   = areq.next_pc + rel_sx;
  assign next_rsp.short_tgt = areq.pair_val + rel_sx;
  assign next_rsp.long_tgt  = areq.pair_val + areq.long_off;
  assign next_rsp.pair_ok   = ~areq.pair_reg[0];
  assign next_rsp.work_ok   = ~areq.work_pair[0];

  // answers are registered one cycle after the request
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      arsp <= '0;
    else
      arsp <= next_rsp;
  end
endmodule // csf_addr_calc
`default_nettype wire

// File: logic/csf_status_flags.sv
// cpu status flag logic with its flags register on apb
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module csf_status_flags
  import csf_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,

  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,

  // datapath operation
  input  wire csf_req_t    req,
  output logic      [7:0]  alu_result,

  // address calculation
  input  wire csf_areq_t   areq,
  output csf_arsp_t        arsp,

  // status toward the core
  output logic      [7:0]  flags,
  output logic      [3:0]  jump_flags,
  output logic             irq_block,
  output logic             fast_return
);

  // ---- arithmetic decode

  logic       op_sub;     // subtract class
  logic       op_arith;   // add or subtract class
  logic       op_cin;     // carry used by adc and sbc
  logic       op_logic;   // and, or, xor
  logic       op_test;    // bit test under mask
  logic       op_shift;   // rotate and shift class
  logic [7:0] ar_res;     // adder result
  logic       ar_c;       // adder carry or borrow
  logic       ar_h;       // adder half carry
  logic       ar_v;       // adder overflow

  assign op_sub   = (req.op == OP_SUB) || (req.op == OP_SBC)
                 || (req.op == OP_CMP);
  assign op_arith = op_sub || (req.op == OP_ADD)
                 || (req.op == OP_ADC);
  assign op_cin   = ((req.op == OP_ADC) || (req.op == OP_SBC))
                 && flags[CSF_C];
  assign op_logic = (req.op == OP_AND) || (req.op == OP_OR)
                 || (req.op == OP_XOR);
  assign op_test  = (req.op == OP_TST) || (req.op == OP_TCM);
  assign op_shift = (req.op == OP_RL) || (req.op == OP_RLC)
                 || (req.op == OP_RR) || (req.op == OP_RRC)
                 || (req.op == OP_SRA) || (req.op == OP_SWAP);

  // shared adder for every arithmetic kind
  csf_arith u_arith (
    .a    (req.a),
    .b    (req.b),
    .cin  (op_cin),
    .sub  (op_sub),
    .res  (ar_res),
    .cout (ar_c),
    .half (ar_h),
    .ovf  (ar_v)
  );

  // operand address unit
  csf_addr_calc u_addr (
    .core_clk (core_clk),
    .nrst     (nrst),
    .areq     (areq),
    .arsp     (arsp)
  );

  // ---- result and shifted-out bit

  logic [7:0] res;     // result of the current operation
  logic       sh_out;  // bit shifted out by a rotate or shift

  // result mux and the bit that leaves the operand
  always_comb
  begin
    res    = req.a;
    sh_out = flags[CSF_C];
    unique case (req.op)
      OP_ADD, OP_ADC, OP_SUB,
      OP_SBC, OP_CMP: res = ar_res;
      OP_AND:  res = req.a & req.b;
      OP_OR:   res = req.a | req.b;
      OP_XOR:  res = req.a ^ req.b;
      // test under mask, and its complement form
      OP_TST:  res = req.a & req.b;
      OP_TCM:  res = ~req.a & req.b;
      OP_RL:
      begin
        res    = {req.a[6:0], req.a[7]};
        sh_out = req.a[7];
      end
      OP_RLC:
      begin
        res    = {req.a[6:0], flags[CSF_C]};
        sh_out = req.a[7];
      end
      OP_RR:
      begin
        res    = {req.a[0], req.a[7:1]};
        sh_out = req.a[0];
      end
      OP_RRC:
      begin
        res    = {flags[CSF_C], req.a[7:1]};
        sh_out = req.a[0];
      end
      OP_SRA:
      begin
        res    = {req.a[7], req.a[7:1]};
        sh_out = req.a[0];
      end
      // nibble swap keeps carry as it was
      OP_SWAP: res = {req.a[3:0], req.a[7:4]};
      default: res = req.a;
    endcase
  end

  // ---- next flag values

  logic [7:0] next_flags;  // flags after the current operation
  logic       res_zero;    // result is all zero

  assign res_zero = (res == 8'h00);

  // flag update chosen by operation class
  always_comb
  begin
    next_flags = flags;
    if (op_arith)
    begin
      next_flags[CSF_C] = ar_c;
      next_flags[CSF_Z] = res_zero;
      next_flags[CSF_S] = res[7];
      next_flags[CSF_V] = ar_v;
      next_flags[CSF_D] = op_sub;
      next_flags[CSF_H] = ar_h;
    end
    else if (op_logic)
    begin
      // and, or, xor update zero, sign and overflow
      next_flags[CSF_Z] = res_zero;
      next_flags[CSF_S] = res[7];
      next_flags[CSF_V] = 1'b0;
    end
    else if (op_test)
    begin
      // bit tests behave as logic on the masked value
      next_flags[CSF_Z] = res_zero;
      next_flags[CSF_S] = res[7];
      next_flags[CSF_V] = 1'b0;
    end
    else if (op_shift)
    begin
      next_flags[CSF_C] = sh_out;
      next_flags[CSF_Z] = res_zero;
      next_flags[CSF_S] = res[7];
    end
    else
    begin
      unique case (req.op)
        OP_SETC:  next_flags[CSF_C]   = 1'b1;
        OP_CLRC:  next_flags[CSF_C]   = 1'b0;
        OP_INVC:  next_flags[CSF_C]   = ~flags[CSF_C];
        OP_SELLO: next_flags[CSF_BA]  = 1'b0;
        OP_SELHI: next_flags[CSF_BA]  = 1'b1;
        OP_FIRQ:  next_flags[CSF_FIS] = 1'b1;
        OP_INTERRUPT_RETURN_OP:  next_flags[CSF_FIS] = 1'b0;
        default:  next_flags = flags;
      endcase
    end
  end

  // ---- apb decode

  logic addr_hit;   // address selects the flags register
  logic acc;        // access phase
  logic wr_hit;     // write to the flags register
  logic op_go;      // an operation completes this cycle

  assign addr_hit = (paddr == CSF_FLAGS_ADDR);
  assign acc      = psel && penable;
  assign wr_hit   = acc && pwrite && addr_hit;
  assign op_go    = req.valid && (req.op != OP_NONE);

  // every access completes in its first access cycle
  assign pready  = 1'b1;
  // unmapped addresses answer with an error
  assign pslverr = acc && !addr_hit;
  // narrow register in the low bits, upper bits zero
  assign prdata  = addr_hit ? {24'h000000, flags} : 32'h00000000;

  // ---- flags register

  // operation wins when software writes in the same cycle
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      flags <= CSF_FLAGS_RST;
    else if (op_go)
      flags <= next_flags;
    else if (wr_hit)
      flags <= pwdata[7:0];
  end

  // ---- result and fast return pulse

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      alu_result  <= 8'h00;
      fast_return <= 1'b0;
    end
    else
    begin
      if (op_go)
        alu_result <= res;
      // return takes the fast path while status is set
      fast_return <= op_go && (req.op == OP_INTERRUPT_RETURN_OP)
                  && flags[CSF_FIS];
    end
  end

  // ---- status outputs

  // decimal and half carry never reach the jump logic
  assign jump_flags = flags[CSF_C:CSF_V];
  // fast interrupt status inhibits every interrupt
  assign irq_block  = flags[CSF_FIS];

  // ---- checks

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  logic [8:0] chk_sum;   // reference sum for a plain add
  logic [4:0] chk_nib;   // reference low nibble sum
  logic       chk_ovf;   // reference signed overflow for a plain add

  assign chk_sum = {1'b0, req.a} + {1'b0, req.b};
  assign chk_nib = {1'b0, req.a[3:0]} + {1'b0, req.b[3:0]};
  // same operand signs and a result sign that differs leaves the range
  assign chk_ovf = (req.a[7] == req.b[7]) && (chk_sum[7] != req.a[7]);

  sequence s_interrupt_return_op_fast;
    op_go && (req.op == OP_INTERRUPT_RETURN_OP) && flags[CSF_FIS];
  endsequence

  sequence s_ret_pulse;
    fast_return && !flags[CSF_FIS] ##1 !fast_return;
  endsequence

  add_carry_a:
    assert property (op_go && req.op == OP_ADD
      |=> flags[CSF_C] == $past(chk_sum[8]))
    else $error("carry wrong after add");

  rot_carry_a:
    assert property (op_go && req.op == OP_RR
      |=> flags[CSF_C] == $past(req.a[0]))
    else $error("carry not last bit out");

  carry_inv_a:
    assert property (op_go && req.op == OP_INVC
      |=> flags[CSF_C] != $past(flags[CSF_C]))
    else $error("carry not inverted");

  logic_zero_a:
    assert property (op_go && op_logic
      |=> flags[CSF_Z] == (alu_result == 8'h00))
    else $error("zero flag disagrees with result");

  sign_copy_a:
    assert property (op_go && (op_arith || op_shift)
      |=> flags[CSF_S] == alu_result[7])
    else $error("sign flag disagrees with result");

  logic_ovf_a:
    assert property (op_go && op_logic |=> !flags[CSF_V])
    else $error("overflow not cleared by logic");

  bcd_kind_a:
    assert property (op_go && op_arith
      |=> flags[CSF_D] == $past(op_sub))
    else $error("decimal flag wrong kind");

  half_add_a:
    assert property (op_go && req.op == OP_ADD
      |=> flags[CSF_H] == $past(chk_nib[4]))
    else $error("half carry wrong after add");

  fis_set_a:
    assert property (op_go && req.op == OP_FIRQ
      |=> irq_block [*1] ##0 flags[CSF_FIS])
    else $error("fast status not set");

  fast_ret_a:
    assert property (s_interrupt_return_op_fast |=> s_ret_pulse)
    else $error("fast return pulse missing");

  bank_sel_a:
    assert property (op_go && req.op == OP_SELHI
      |=> flags[CSF_BA] ##0 $stable(flags[CSF_C]))
    else $error("upper bank not selected");

  load_write_a:
    assert property (wr_hit && !op_go
      |=> flags == $past(pwdata[7:0]))
    else $error("direct write lost");

  add_ovf_a:
    assert property (op_go && req.op == OP_ADD
      |=> flags[CSF_V] == $past(chk_ovf))
    else $error("overflow wrong after add");

  shift_zero_a:
    assert property (op_go && op_shift
      |=> flags[CSF_Z] == (alu_result == 8'h00))
    else $error("zero flag wrong after shift");

  and_flags_a:
    assert property (op_go && req.op == OP_AND
      |=> flags[CSF_Z] == (alu_result == 8'h00)
          && flags[CSF_S] == alu_result[7] && !flags[CSF_V])
    else $error("and did not update flags");

  bank_low_a:
    assert property (op_go && req.op == OP_SELLO |=> !flags[CSF_BA])
    else $error("lower bank not selected");

  interrupt_return_op_clear_a:
    assert property (op_go && req.op == OP_INTERRUPT_RETURN_OP |=> !flags[CSF_FIS] && !irq_block)
    else $error("fast status not cleared");

endmodule // csf_status_flags
`default_nettype wire

// File: tb/test_cpu_status_flag_logic.sv
// self-checking bench for the cpu status flag logic
`timescale 1ns/10ps
`default_nettype none
module test_cpu_status_flag_logic;
  import csf_pkg::*;

  logic        core_clk;    // 20 MHz core clock
  logic        nrst;        // async reset, active low
  logic        psel;        // apb select
  logic        penable;     // apb access phase
  logic        pwrite;      // apb direction
  logic [11:0] paddr;       // apb byte address
  logic [31:0] pwdata;      // apb write data
  logic [31:0] prdata;      // apb read data
  logic        pready;      // apb ready
  logic        pslverr;     // apb error
  csf_req_t    req;         // datapath operation
  logic [7:0]  alu_result;  // registered result
  csf_areq_t   areq;        // address request
  csf_arsp_t   arsp;        // address answer
  logic [7:0]  flags;       // flags register
  logic [3:0]  jump_flags;  // condition flags
  logic        irq_block;   // interrupt block
  logic        fast_return; // fast return pulse
  logic [31:0] rd;          // read data taken
  logic        er;          // error taken
  int          num_errors;  // mismatch count
  int          checks;      // comparison count

  // device under test
  csf_status_flags u_dut (
    .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req(req), .alu_result(alu_result),
    .areq(areq), .arsp(arsp), .flags(flags), .jump_flags(jump_flags),
    .irq_block(irq_block), .fast_return(fast_return)
  );

  // clock of 50 ns period
  always #25 core_clk = ~core_clk;

  // verdict and end of run
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one comparison
  task automatic check(input logic [79:0] s, input logic [79:0] e);
    checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge core_clk);
      n++;
    end
    // a slave that never answers ends the run
    if (n >= 50)
    begin
      num_errors++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  // one datapath operation, then the flags are compared
  task automatic run_op(input csf_op_t o, input logic [7:0] a, b, r, f, input logic cr);
    @(posedge core_clk);
    req <= '{valid: 1'b1, op: o, a: a, b: b};
    @(posedge core_clk);
    req.valid <= 1'b0;
    #1;
    check(flags, f);
    check(jump_flags, f[7:4]);
    check(irq_block, f[1]);
    if (cr)
      check(alu_result, r);
  endtask

  // one address calculation
  task automatic addr_chk(input csf_areq_t q, input csf_arsp_t e);
    @(posedge core_clk);
    areq <= q;
    @(posedge core_clk);
    #1;
    check(arsp, e);
  endtask

  // watchdog
  initial
  begin
    #(5000 * 50);
    num_errors++;
    report_and_stop();
  end

  // main sequence
  initial
  begin
    core_clk = 1'b0; nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; req = '0; areq = '0; num_errors = 0; checks = 0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    #1;
    check(flags, CSF_FLAGS_RST);
    // direct write and read back of the flags register, never during an op
    apb(1'b1, CSF_FLAGS_ADDR, 32'hffffffa5);
    check(er, 1'b0);
    apb(1'b0, CSF_FLAGS_ADDR, 32'h0);
    check(rd, 32'h000000a5);
    check(jump_flags, 4'ha);
    apb(1'b1, 12'h350, 32'h0000005a);
    check(er, 1'b1);
    check(flags, 8'ha5);
    apb(1'b0, 12'h350, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, CSF_FLAGS_ADDR, 32'h0);
    // arithmetic
    run_op(OP_ADD, 8'h7f, 8'h01, 8'h80, 8'h34, 1'b1);
    run_op(OP_ADD, 8'hff, 8'h01, 8'h00, 8'hc4, 1'b1);
    run_op(OP_ADC, 8'h00, 8'h00, 8'h01, 8'h00, 1'b1);
    run_op(OP_SUB, 8'h00, 8'h01, 8'hff, 8'hac, 1'b1);
    run_op(OP_SBC, 8'h00, 8'h00, 8'hff, 8'hac, 1'b1);
    run_op(OP_SUB, 8'h80, 8'h01, 8'h7f, 8'h1c, 1'b1);
    run_op(OP_CMP, 8'h05, 8'h05, 8'h00, 8'h48, 1'b0);
    run_op(OP_SUB, 8'h80, 8'h01, 8'h7f, 8'h1c, 1'b1);
    // logic and bit tests
    run_op(OP_AND, 8'hf0, 8'h0f, 8'h00, 8'h4c, 1'b1);
    run_op(OP_OR, 8'h80, 8'h01, 8'h81, 8'h2c, 1'b1);
    run_op(OP_XOR, 8'hff, 8'hff, 8'h00, 8'h4c, 1'b1);
    run_op(OP_TCM, 8'h7f, 8'h80, 8'h00, 8'h2c, 1'b0);
    run_op(OP_TST, 8'h0f, 8'h10, 8'h00, 8'h4c, 1'b0);
    // rotate and shift
    run_op(OP_RL, 8'h81, 8'h00, 8'h03, 8'h8c, 1'b1);
    run_op(OP_RLC, 8'h00, 8'h00, 8'h01, 8'h0c, 1'b1);
    run_op(OP_RRC, 8'h01, 8'h00, 8'h00, 8'hcc, 1'b1);
    run_op(OP_RR, 8'h01, 8'h00, 8'h80, 8'hac, 1'b1);
    run_op(OP_SRA, 8'h02, 8'h00, 8'h01, 8'h0c, 1'b1);
    run_op(OP_SRA, 8'h81, 8'h00, 8'hc0, 8'hac, 1'b1);
    run_op(OP_SWAP, 8'h3c, 8'h00, 8'hc3, 8'hac, 1'b1);
    // carry control, bank select, ignored operation
    run_op(OP_CLRC, 8'h00, 8'h00, 8'h00, 8'h2c, 1'b0);
    run_op(OP_SETC, 8'h00, 8'h00, 8'h00, 8'hac, 1'b0);
    run_op(OP_INVC, 8'h00, 8'h00, 8'h00, 8'h2c, 1'b0);
    run_op(OP_INVC, 8'h00, 8'h00, 8'h00, 8'hac, 1'b0);
    run_op(OP_SELHI, 8'h00, 8'h00, 8'h00, 8'had, 1'b0);
    run_op(OP_SELLO, 8'h00, 8'h00, 8'h00, 8'hac, 1'b0);
    run_op(OP_NONE, 8'hff, 8'hff, 8'h00, 8'hac, 1'b0);
    // fast interrupt status and return
    run_op(OP_FIRQ, 8'h00, 8'h00, 8'h00, 8'hae, 1'b0);
    run_op(OP_ADD, 8'h01, 8'h01, 8'h02, 8'h02, 1'b1);
    run_op(OP_INTERRUPT_RETURN_OP, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    check(fast_return, 1'b1);
    run_op(OP_INTERRUPT_RETURN_OP, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    check(fast_return, 1'b0);
    // operand address calculation at the range ends
    addr_chk('{8'hfe, 4'he, 8'h80, 16'h1000, 16'h2000, 16'hffff},
             '{16'h0f80, 16'h1f80, 16'h1fff, 1'b1, 1'b1});
    addr_chk('{8'h01, 4'h3, 8'h7f, 16'h1000, 16'h2000, 16'h0001},
             '{16'h107f, 16'h207f, 16'h2001, 1'b0, 1'b0});
    // reset in mid-run, then one operation after release
    apb(1'b1, CSF_FLAGS_ADDR, 32'h000000ff);
    check(irq_block, 1'b1);
    @(posedge core_clk);
    nrst <= 1'b0;
    @(posedge core_clk);
    #1;
    check(flags, CSF_FLAGS_RST);
    check(irq_block, 1'b0);
    check(fast_return, 1'b0);
    @(posedge core_clk);
    nrst <= 1'b1;
    run_op(OP_SETC, 8'h00, 8'h00, 8'h00, 8'h80, 1'b0);
    report_and_stop();
  end
endmodule // test_cpu_status_flag_logic
`default_nettype wire
